/* File: aeq_pkg.sv */
// Shared constants, types and helpers for the audio EQ, volume and delay chain.
package aeq_pkg;
    localparam int SMP_W = 24;
    localparam int DAT_W = 26;
    localparam int COEF_W = 22;
    localparam int CFRAC = 20;
    localparam int DBL_W = 46;
    localparam int ACC_W = 52;
    localparam int N_SEC = 21;
    localparam int N_COEF = 5;
    localparam int N_CH = 3;
    localparam int ADDR_W = 7;
    localparam int RAM_N = 128;
    localparam int DLY_AW = 9;
    localparam int DLY_DEPTH = 512;

    // Last section index of each filter group.
    localparam logic [4:0] EQ_L_END = 5'h06;
    localparam logic [4:0] EQ_R_END = 5'h0D;
    localparam logic [4:0] MX_L_END = 5'h0F;
    localparam logic [4:0] MX_R_END = 5'h11;
    localparam logic [4:0] SUB_END = 5'h14;

    // Parameter RAM map: section k coefficients at 5k..5k+4, then the loose settings.
    localparam logic [ADDR_W-1:0] ADDR_COEF_END = 7'h68;
    localparam logic [ADDR_W-1:0] ADDR_VOL_L = 7'h69;
    localparam logic [ADDR_W-1:0] ADDR_VOL_S = 7'h6B;
    localparam logic [ADDR_W-1:0] ADDR_WID_LVL = 7'h6C;
    localparam logic [ADDR_W-1:0] ADDR_WID_ALPHA = 7'h6D;
    localparam logic [ADDR_W-1:0] ADDR_DLY_L = 7'h6E;
    localparam logic [ADDR_W-1:0] ADDR_DLY_S = 7'h70;

    localparam logic signed [COEF_W-1:0] UNITY = 22'h10_0000;
    localparam int FULL_SCALE = 2097152;
    localparam int RAMP_FAST_FRAMES = 1024;
    localparam int RAMP_SLOW_FRAMES = 8192;
    localparam logic signed [COEF_W:0] STEP_FAST = (COEF_W+1)'(FULL_SCALE / RAMP_FAST_FRAMES);
    localparam logic signed [COEF_W:0] STEP_SLOW = (COEF_W+1)'(FULL_SCALE / RAMP_SLOW_FRAMES);

    localparam logic [DLY_AW-1:0] DLY_MAX = 9'h0A5;
    localparam logic [DLY_AW-1:0] LOOKAHEAD = 9'h064;

    localparam logic signed [DAT_W-1:0] DAT_MAX = 26'h1FF_FFFF;
    localparam logic signed [DAT_W-1:0] DAT_MIN = 26'h200_0000;
    localparam logic signed [DBL_W-1:0] DBL_MAX = 46'h1FFF_FFFF_FFFF;
    localparam logic signed [DBL_W-1:0] DBL_MIN = 46'h2000_0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BQ = 2'b01,
        ST_WAIT = 2'b10,
        ST_POST = 2'b11
    } aeq_state_e;

    // Clip a 3.23-scaled accumulator value into the 26-bit signal format.
    function automatic logic signed [DAT_W-1:0] aeq_sat(input logic signed [ACC_W-1:0] a);
        if (&a[ACC_W-1:DAT_W-1] || ~|a[ACC_W-1:DAT_W-1])
            return a[DAT_W-1:0];
        return a[ACC_W-1] ? DAT_MIN : DAT_MAX;
    endfunction
endpackage

/* File: aeq_bq_if.sv */
// Interface between the frame sequencer and the second-order section engine.
interface aeq_bq_if;
    import aeq_pkg::*;
    logic start;
    logic done;
    logic signed [DAT_W-1:0] x;
    logic signed [DAT_W-1:0] x1;
    logic signed [DAT_W-1:0] x2;
    logic signed [DBL_W-1:0] y1;
    logic signed [DBL_W-1:0] y2;
    logic signed [COEF_W-1:0] c [N_COEF];
    logic signed [DAT_W-1:0] y;
    logic signed [DBL_W-1:0] yd;
    modport eng (input start, x, x1, x2, y1, y2, c, output done, y, yd);
    modport seq (output start, x, x1, x2, y1, y2, c, input done, y, yd);
endinterface

/* File: aeq_biquad.sv */
// One second-order section, computed in a single cycle with a registered result.
module aeq_biquad
    import aeq_pkg::*;
(
    input logic clk_sys,
    input logic rstn,
    input logic ce,
    aeq_bq_if.eng bq
);
    logic signed [DBL_W+COEF_W-1:0] py1;
    logic signed [DBL_W+COEF_W-1:0] py2;
    logic signed [ACC_W-1:0] acc;
    logic signed [DBL_W-1:0] yd_r, yd_nxt;
    logic done_r, done_nxt;

    // Feedback state is kept at 3.43 so low-frequency poles do not settle into limit cycles.
    always_comb
    begin
        py1 = bq.y1 * bq.c[3];
        py2 = bq.y2 * bq.c[4];
        // Inputs are widened before the multiply so the products keep their full width.
        acc = ACC_W'(bq.x) * bq.c[0] + ACC_W'(bq.x1) * bq.c[1] + ACC_W'(bq.x2) * bq.c[2]
            + ACC_W'(py1 >>> CFRAC) + ACC_W'(py2 >>> CFRAC); // RULE5 RULE6 RULE7
        done_nxt = bq.start;
        yd_nxt = yd_r;
        if (bq.start)
        begin
            if (&acc[ACC_W-1:DBL_W-1] || ~|acc[ACC_W-1:DBL_W-1])
                yd_nxt = acc[DBL_W-1:0];
            else
                yd_nxt = acc[ACC_W-1] ? DBL_MIN : DBL_MAX; // RULE22
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            done_r <= 1'b0;
            yd_r <= '0;
        end
        else if (ce)
        begin
            done_r <= done_nxt;
            yd_r <= yd_nxt;
        end
    end

    assign bq.done = done_r;
    assign bq.yd = yd_r;
    assign bq.y = yd_r[DBL_W-1:DBL_W-DAT_W];

    property p_bq_sat;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && bq.start && !acc[ACC_W-1] && |acc[ACC_W-2:DBL_W-1]) |=> (bq.yd == DBL_MAX && bq.done);
    endproperty
    a_bq_sat: assert property (p_bq_sat) else $error("section overflow not clipped"); // RULE22
    c_bq_sat: cover property (@(posedge clk_sys) disable iff (!rstn) ce && bq.start && acc[ACC_W-1]
        && !(&acc[ACC_W-2:DBL_W-1]));
endmodule // aeq_biquad

/* File: aeq_chain.sv */
// Frame sequencer: filter sections, widener, volume ramps and per-channel delay.
// Notes on behaviour
// RULE1: Seven shared EQ sections per input channel.
// RULE2: Two extra sections on each main channel.
// RULE3: Three extra sections on the sub channel.
// RULE4: Crossover groups both fed from EQ output.
// RULE5: Section sums feedforward and added feedback products.
// RULE6: Coefficients are signed 2.20 fixed point.
// RULE7: Double-precision accumulation and feedback state.
// RULE8: Host writes parameter RAM; filters use it.
// RULE9: Host should update coefficients safely.
// RULE10: Shutdown ramps volume down, release restores.
// RULE11: Input sign-extended with two headroom bits.
// RULE12: Three ramped volumes: left, right, sub.
// RULE13: Volume is signed 2.20, default 1.0.
// RULE14: Fast ramp: 1024 frames from 2.0.
// RULE15: Slow ramp: 8192 frames from 2.0.
// RULE16: Mute ramps to zero, keeps stored volume.
// RULE17: Volume applied after the filter sections.
// RULE18: Widener adds filtered difference, opposite signs.
// RULE19: Widener low-pass uses stored smoothing coefficient.
// RULE20: Programmable per-channel delay up to 165.
// RULE21: Left/right add fixed 100-sample look-ahead.
// RULE22: Accumulator overflow saturates to 3.23.
// RULE23: Ramp moves fixed step per frame.
// RULE24: Oversized delay setting clamps to maximum.
module aeq_chain
    import aeq_pkg::*;
(
    input logic clk_sys,
    input logic rstn,
    input logic ce,
    input logic in_valid,
    input logic signed [SMP_W-1:0] in_l,
    input logic signed [SMP_W-1:0] in_r,
    input logic prm_we,
    input logic [ADDR_W-1:0] prm_addr,
    input logic signed [COEF_W-1:0] prm_wdata,
    input logic mute,
    input logic slow_ramp,
    input logic shutdown,
    output logic busy,
    output logic out_valid,
    output logic signed [DAT_W-1:0] out_l,
    output logic signed [DAT_W-1:0] out_r,
    output logic signed [DAT_W-1:0] out_s
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    aeq_state_e state_r, state_nxt;
    logic [4:0] sec_r, sec_nxt;
    logic signed [DAT_W-1:0] cur_r, cur_nxt, inr_r, inr_nxt;
    logic signed [DAT_W-1:0] eql_r, eql_nxt, eqr_r, eqr_nxt;
    logic signed [DAT_W-1:0] chl_r, chl_nxt, chr_r, chr_nxt, chs_r, chs_nxt;
    logic signed [DAT_W-1:0] lp_r, lp_nxt;
    logic signed [DAT_W-1:0] sx1_r [N_SEC];
    logic signed [DAT_W-1:0] sx1_nxt [N_SEC];
    logic signed [DAT_W-1:0] sx2_r [N_SEC];
    logic signed [DAT_W-1:0] sx2_nxt [N_SEC];
    logic signed [DBL_W-1:0] sy1_r [N_SEC];
    logic signed [DBL_W-1:0] sy1_nxt [N_SEC];
    logic signed [DBL_W-1:0] sy2_r [N_SEC];
    logic signed [DBL_W-1:0] sy2_nxt [N_SEC];
    logic signed [COEF_W-1:0] prm_r [RAM_N];
    logic signed [COEF_W-1:0] prm_nxt [RAM_N];
    logic signed [COEF_W-1:0] gain_r [N_CH];
    logic signed [COEF_W-1:0] gain_nxt [N_CH];
    logic signed [DAT_W-1:0] obuf_r [N_CH];
    logic signed [DAT_W-1:0] obuf_nxt [N_CH];
    logic [DLY_AW-1:0] wp_r, wp_nxt;
    logic oval_r, oval_nxt;

    logic post;
    logic signed [DAT_W-1:0] avg;
    logic signed [ACC_W-1:0] t;
    logic signed [ACC_W-1:0] w;
    logic signed [COEF_W-1:0] tgt;
    logic signed [COEF_W:0] gdiff;
    logic signed [COEF_W:0] step;
    logic signed [COEF_W:0] gmv;
    logic signed [DAT_W-1:0] vin [N_CH];
    logic signed [DAT_W-1:0] vm [N_CH];
    logic signed [DAT_W-1:0] dout [N_CH];

    aeq_bq_if bq ();

    aeq_biquad u_bq (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .bq(bq)
    );

    // ----------------------------------------------------------------
    // Section engine feed
    // ----------------------------------------------------------------
    assign post = (state_r == ST_POST);
    assign busy = (state_r != ST_IDLE);
    assign bq.start = (state_r == ST_BQ);
    assign bq.x = cur_r;
    assign bq.x1 = sx1_r[sec_r];
    assign bq.x2 = sx2_r[sec_r];
    assign bq.y1 = sy1_r[sec_r];
    assign bq.y2 = sy2_r[sec_r];
    assign avg = DAT_W'((ACC_W'(eql_r) + ACC_W'(eqr_r)) >>> 1);

    always_comb
    begin
        for (int k = 0; k < N_COEF; k++)
            bq.c[k] = prm_r[ADDR_W'(sec_r * N_COEF + k)]; // RULE8
    end

    // ----------------------------------------------------------------
    // Widener, volume and delay datapath
    // ----------------------------------------------------------------
    // The low-pass and the gain multiply share one post cycle per frame.
    always_comb
    begin
        t = ACC_W'(chl_r) - ACC_W'(chr_r) - ACC_W'(lp_r);
        t = (t * prm_r[ADDR_WID_ALPHA]) >>> CFRAC; // RULE19
        lp_nxt = post ? aeq_sat(ACC_W'(lp_r) + t) : lp_r;
        w = (ACC_W'(lp_nxt) * prm_r[ADDR_WID_LVL]) >>> CFRAC;
        vin[0] = aeq_sat(ACC_W'(chl_r) + w); // RULE18
        vin[1] = aeq_sat(ACC_W'(chr_r) - w); // RULE18
        vin[2] = chs_r;
        for (int ch = 0; ch < N_CH; ch++)
            vm[ch] = aeq_sat((ACC_W'(vin[ch]) * gain_r[ch]) >>> CFRAC); // RULE17
    end

    for (genvar ch = 0; ch < N_CH; ch++)
    begin : g_dly
        logic signed [DAT_W-1:0] mem [DLY_DEPTH];
        logic [DLY_AW-1:0] dly;
        always_comb
        begin
            if ($unsigned(prm_r[ADDR_DLY_L + ADDR_W'(ch)]) > COEF_W'(DLY_MAX))
                dly = DLY_MAX; // RULE24
            else
                dly = prm_r[ADDR_DLY_L + ADDR_W'(ch)][DLY_AW-1:0]; // RULE20
            if (ch < 2)
                dly = dly + LOOKAHEAD; // RULE21
        end
        // Delay lines carry no reset; they hold audio only.
        always_ff @(posedge clk_sys)
        begin
            if (ce && post)
                mem[wp_r] <= vm[ch];
        end
        assign dout[ch] = (dly == '0) ? vm[ch] : mem[wp_r - dly]; // RULE20
    end

    // ----------------------------------------------------------------
    // Volume ramps
    // ----------------------------------------------------------------
    always_comb
    begin
        tgt = '0;
        gdiff = '0;
        step = slow_ramp ? STEP_SLOW : STEP_FAST; // RULE14 RULE15
        for (int ch = 0; ch < N_CH; ch++)
        begin
            gain_nxt[ch] = gain_r[ch];
            tgt = (mute || shutdown) ? '0 : prm_r[ADDR_VOL_L + ADDR_W'(ch)]; // RULE16 RULE10 RULE12
            gdiff = {tgt[COEF_W-1], tgt} - {gain_r[ch][COEF_W-1], gain_r[ch]};
            if (post)
            begin
                if (gdiff > step)
                    gain_nxt[ch] = gain_r[ch] + COEF_W'(step); // RULE23
                else if (gdiff < -step)
                    gain_nxt[ch] = gain_r[ch] - COEF_W'(step); // RULE23
                else
                    gain_nxt[ch] = tgt;
            end
        end
        gmv = {gain_nxt[0][COEF_W-1], gain_nxt[0]} - {gain_r[0][COEF_W-1], gain_r[0]};
    end

    // ----------------------------------------------------------------
    // Frame sequencer and parameter RAM
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        sec_nxt = sec_r;
        cur_nxt = cur_r;
        inr_nxt = inr_r;
        eql_nxt = eql_r;
        eqr_nxt = eqr_r;
        chl_nxt = chl_r;
        chr_nxt = chr_r;
        chs_nxt = chs_r;
        sx1_nxt = sx1_r;
        sx2_nxt = sx2_r;
        sy1_nxt = sy1_r;
        sy2_nxt = sy2_r;
        prm_nxt = prm_r;
        obuf_nxt = obuf_r;
        wp_nxt = wp_r;
        oval_nxt = 1'b0;
        if (prm_we)
            prm_nxt[prm_addr] = prm_wdata; // RULE8
        case (state_r)
            ST_IDLE:
            begin
                if (in_valid)
                begin
                    cur_nxt = DAT_W'(in_l); // RULE11
                    inr_nxt = DAT_W'(in_r); // RULE11
                    sec_nxt = '0;
                    state_nxt = ST_BQ;
                end
            end
            ST_BQ:
                state_nxt = ST_WAIT;
            ST_WAIT:
            begin
                if (bq.done)
                begin
                    sx1_nxt[sec_r] = cur_r;
                    sx2_nxt[sec_r] = sx1_r[sec_r];
                    sy1_nxt[sec_r] = bq.yd;
                    sy2_nxt[sec_r] = sy1_r[sec_r];
                    sec_nxt = sec_r + 5'h01;
                    state_nxt = ST_BQ;
                    cur_nxt = bq.y; // RULE1
                    if (sec_r == EQ_L_END)
                    begin
                        eql_nxt = bq.y;
                        cur_nxt = inr_r;
                    end
                    else if (sec_r == EQ_R_END)
                    begin
                        eqr_nxt = bq.y;
                        cur_nxt = eql_r; // RULE4 RULE2
                    end
                    else if (sec_r == MX_L_END)
                    begin
                        chl_nxt = bq.y;
                        cur_nxt = eqr_r; // RULE4 RULE2
                    end
                    else if (sec_r == MX_R_END)
                    begin
                        chr_nxt = bq.y;
                        cur_nxt = avg; // RULE4 RULE3
                    end
                    else if (sec_r == SUB_END)
                    begin
                        chs_nxt = bq.y; // RULE3
                        state_nxt = ST_POST;
                    end
                end
            end
            ST_POST:
            begin
                obuf_nxt = dout;
                oval_nxt = 1'b1;
                wp_nxt = wp_r + 9'h001;
                state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_IDLE;
            sec_r <= '0;
            cur_r <= '0;
            inr_r <= '0;
            eql_r <= '0;
            eqr_r <= '0;
            chl_r <= '0;
            chr_r <= '0;
            chs_r <= '0;
            lp_r <= '0;
            wp_r <= '0;
            oval_r <= 1'b0;
            for (int i = 0; i < N_SEC; i++)
            begin
                sx1_r[i] <= '0;
                sx2_r[i] <= '0;
                sy1_r[i] <= '0;
                sy2_r[i] <= '0;
            end
            // Sections start as pass-through and volumes at unity.
            for (int i = 0; i < RAM_N; i++)
                prm_r[i] <= ((i % N_COEF == 0 && i <= ADDR_COEF_END) || (i >= ADDR_VOL_L && i <= ADDR_VOL_S))
                    ? UNITY : '0; // RULE13
            for (int i = 0; i < N_CH; i++)
            begin
                gain_r[i] <= UNITY; // RULE13
                obuf_r[i] <= '0;
            end
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            sec_r <= sec_nxt;
            cur_r <= cur_nxt;
            inr_r <= inr_nxt;
            eql_r <= eql_nxt;
            eqr_r <= eqr_nxt;
            chl_r <= chl_nxt;
            chr_r <= chr_nxt;
            chs_r <= chs_nxt;
            lp_r <= lp_nxt;
            wp_r <= wp_nxt;
            oval_r <= oval_nxt;
            sx1_r <= sx1_nxt;
            sx2_r <= sx2_nxt;
            sy1_r <= sy1_nxt;
            sy2_r <= sy2_nxt;
            prm_r <= prm_nxt;
            gain_r <= gain_nxt;
            obuf_r <= obuf_nxt;
        end
    end

    assign out_valid = oval_r;
    assign out_l = obuf_r[0];
    assign out_r = obuf_r[1];
    assign out_s = obuf_r[2];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_sec_step;
        (ce && state_r == ST_WAIT && bq.done && sec_r != SUB_END) |=> (sec_r == $past(sec_r) + 5'h01);
    endproperty
    a_sec_step: assert property (p_sec_step) else $error("section index skipped"); // RULE1

    property p_in_ext;
        (ce && state_r == ST_IDLE && in_valid) |=> (cur_r == DAT_W'($past(in_l)) && sec_r == '0);
    endproperty
    a_in_ext: assert property (p_in_ext) else $error("input not sign-extended"); // RULE11

    property p_sub_src;
        (ce && state_r == ST_WAIT && bq.done && sec_r == MX_R_END) |=> (cur_r == $past(avg));
    endproperty
    a_sub_src: assert property (p_sub_src) else $error("sub path not fed from EQ sum"); // RULE4

    property p_fast;
        (ce && post && !slow_ramp) |-> (gmv <= STEP_FAST && gmv >= -STEP_FAST);
    endproperty
    a_fast: assert property (p_fast) else $error("fast ramp step too large"); // RULE14

    property p_slow;
        (ce && post && slow_ramp) |-> (gmv <= STEP_SLOW && gmv >= -STEP_SLOW);
    endproperty
    a_slow: assert property (p_slow) else $error("slow ramp step too large"); // RULE15

    property p_mute;
        (ce && post && (mute || shutdown) && gain_r[0] > 0) |=> (gain_r[0] < $past(gain_r[0]));
    endproperty
    a_mute: assert property (p_mute) else $error("mute did not lower gain"); // RULE16

    property p_clamp;
        (g_dly[2].dly <= DLY_MAX) && (g_dly[0].dly <= DLY_MAX + LOOKAHEAD);
    endproperty
    a_clamp: assert property (p_clamp) else $error("delay beyond maximum"); // RULE24

    property p_look;
        (prm_r[ADDR_DLY_L] == prm_r[ADDR_DLY_S]) |-> (g_dly[0].dly == g_dly[2].dly + LOOKAHEAD);
    endproperty
    a_look: assert property (p_look) else $error("look-ahead delay missing"); // RULE21

    property p_prm_wr;
        (ce && prm_we) |=> (prm_r[$past(prm_addr)] == $past(prm_wdata));
    endproperty
    a_prm_wr: assert property (p_prm_wr) else $error("parameter write lost"); // RULE8

    property p_centre;
        (post && chl_r == chr_r && lp_r == '0) |-> (vin[0] == chl_r && vin[1] == chr_r);
    endproperty
    a_centre: assert property (p_centre) else $error("centre content altered"); // RULE18

    c_frame: cover property (ce && post);
    c_mute_zero: cover property (mute && gain_r[0] == '0);
    c_max_dly: cover property (post && g_dly[0].dly == DLY_MAX + LOOKAHEAD);
endmodule // aeq_chain

/* File: aeq_src_model.sv */
// Source and host model: audio frames into the chain and parameter words into its RAM.
module aeq_src_model
    import aeq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic busy,
    output logic in_valid,
    output logic signed [SMP_W-1:0] in_l,
    output logic signed [SMP_W-1:0] in_r,
    output logic prm_we,
    output logic [ADDR_W-1:0] prm_addr,
    output logic signed [COEF_W-1:0] prm_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        in_valid = 1'b0;
        in_l = 24'h00_0000;
        in_r = 24'h00_0000;
        prm_we = 1'b0;
        prm_addr = 7'h00;
        prm_wdata = 22'h00_0000;
    end

    // ---------------------------------------------------------------
    // Transfers
    // ---------------------------------------------------------------
    // Released data lines are inverted so a stale sample can never pass for a fresh one.
    task automatic send(input logic signed [SMP_W-1:0] l, input logic signed [SMP_W-1:0] r);
        @(posedge clk_sys);
        in_valid <= 1'b1;
        in_l <= l;
        in_r <= r;
        @(posedge clk_sys);
        while (busy !== 1'b0)
            @(posedge clk_sys);
        in_valid <= 1'b0;
        in_l <= ~l;
        in_r <= ~r;
    endtask

    // Words go in only between frames, so no frame sees a half-written set.
    task automatic write(input logic [ADDR_W-1:0] a, input logic signed [COEF_W-1:0] d);
        @(posedge clk_sys);
        while (busy !== 1'b0)
            @(posedge clk_sys);
        prm_we <= 1'b1;
        prm_addr <= a;
        prm_wdata <= d;
        @(posedge clk_sys);
        prm_we <= 1'b0;
        prm_wdata <= ~d;
    endtask
endmodule // aeq_src_model

/* File: test_aeq_chain.sv */
// Self-checking bench for the audio EQ, volume and delay chain.
module test_aeq_chain import aeq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int X1 = 32'h0010_0000;
    localparam int KW = 32'h0000_1000;
    logic clk_sys;
    logic rstn;
    logic ce;
    logic in_valid;
    logic prm_we;
    logic mute;
    logic slow_ramp;
    logic shutdown;
    logic busy;
    logic out_valid;
    logic signed [SMP_W-1:0] in_l;
    logic signed [SMP_W-1:0] in_r;
    logic [ADDR_W-1:0] prm_addr;
    logic signed [COEF_W-1:0] prm_wdata;
    logic signed [DAT_W-1:0] out_l;
    logic signed [DAT_W-1:0] out_r;
    logic signed [DAT_W-1:0] out_s;
    int checks = 0;
    int mismatches = 0;
    int cycles = 0;

    aeq_chain uut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .in_valid(in_valid), .in_l(in_l), .in_r(in_r),
        .prm_we(prm_we), .prm_addr(prm_addr), .prm_wdata(prm_wdata), .mute(mute), .slow_ramp(slow_ramp),
        .shutdown(shutdown), .busy(busy), .out_valid(out_valid), .out_l(out_l), .out_r(out_r), .out_s(out_s));
    aeq_src_model src (.clk_sys(clk_sys), .busy(busy), .in_valid(in_valid), .in_l(in_l), .in_r(in_r),
        .prm_we(prm_we), .prm_addr(prm_addr), .prm_wdata(prm_wdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] want);
        checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic frame(input int l, input int r);
        int n;
        n = 0;
        src.send(SMP_W'(l), SMP_W'(r));
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (out_valid !== 1'b1 && n < 100);
        check(DAT_W'(n), DAT_W'(44));
    endtask

    // Counts gain steps on the sub output; the input is chosen so the output equals the gain.
    task automatic ramp(input int start, input int step, input int target, input int cnt_exp);
        int prev;
        int d;
        int cnt;
        prev = start;
        cnt = 0;
        for (int n = 0; n < cnt_exp + 8; n++)
        begin
            frame(X1, X1);
            d = int'(out_s) - prev;
            prev = int'(out_s);
            if (d != 0)
            begin
                cnt++;
                check(DAT_W'(d < 0 ? -d : d), DAT_W'(step));
            end
        end
        check(DAT_W'(prev), DAT_W'(target));
        check(DAT_W'(cnt), DAT_W'(cnt_exp));
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_filter();
        logic [ADDR_W-1:0] sec [4] = '{7'h1E, 7'h23, 7'h46, 7'h55};
        logic [DAT_W-1:0] want [4] = '{26'h00C_0000, 26'h00C_0000, 26'h010_0000, 26'h010_0000};
        frame(X1, X1);
        check(out_s, 26'h010_0000);
        foreach (sec[i])
        begin
            src.write(sec[i], 22'h08_0000);
            frame(X1, X1);
            check(out_s, want[i]);
            src.write(sec[i], UNITY);
        end
        src.write(7'h5D, 22'h08_0000);
        for (int k = 0; k < 3; k++)
        begin
            frame(0, 0);
            check(out_s, DAT_W'(32'h0008_0000 >> k));
        end
        src.write(7'h5D, 22'h00_0000);
        src.write(7'h5A, 22'h30_0000);
        frame(X1, X1);
        check(out_s, 26'h3F0_0000);
        src.write(7'h5A, 22'h1F_FFFF);
        src.write(7'h5F, 22'h1F_FFFF);
        src.write(7'h64, 22'h1F_FFFF);
        frame(32'h007F_FFFF, 32'h007F_FFFF);
        check(out_s, DAT_MAX);
        frame(-32'h0080_0000, -32'h0080_0000);
        check(out_s, DAT_MIN);
        src.write(7'h5A, UNITY);
        src.write(7'h5F, UNITY);
        src.write(7'h64, UNITY);
    endtask

    task automatic t_delay();
        src.write(ADDR_DLY_L + 7'h01, 22'h00_0041);
        src.write(ADDR_DLY_S, 22'h00_00C8);
        src.write(ADDR_WID_LVL, 22'h08_0000);
        src.write(ADDR_WID_ALPHA, UNITY);
        for (int n = 0; n < 180; n++)
        begin
            frame(n * 256 + KW, n * 256 - KW);
            if (n >= 170)
            begin
                check(out_l, DAT_W'((n - 100) * 256 + 2 * KW));
                check(out_r, DAT_W'((n - 165) * 256 - 2 * KW));
                check(out_s, DAT_W'((n - 165) * 256));
            end
        end
        src.write(ADDR_WID_LVL, 22'h00_0000);
        src.write(ADDR_DLY_S, 22'h00_0000);
    endtask

    task automatic t_ramps();
        src.write(ADDR_VOL_S, 22'h00_0000);
        ramp(X1, 32'h800, 0, 512);
        @(posedge clk_sys);
        slow_ramp <= 1'b1;
        src.write(ADDR_VOL_S, 22'h01_0000);
        ramp(0, 32'h100, 32'h1_0000, 256);
        @(posedge clk_sys);
        slow_ramp <= 1'b0;
        mute <= 1'b1;
        ramp(32'h1_0000, 32'h800, 0, 32);
        @(posedge clk_sys);
        mute <= 1'b0;
        ramp(0, 32'h800, 32'h1_0000, 32);
        @(posedge clk_sys);
        shutdown <= 1'b1;
        ramp(32'h1_0000, 32'h800, 0, 32);
        @(posedge clk_sys);
        shutdown <= 1'b0;
        ramp(0, 32'h800, 32'h1_0000, 32);
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        mute = 1'b0;
        slow_ramp = 1'b0;
        shutdown = 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        t_filter();
        t_delay();
        t_ramps();
        close_out();
    end
endmodule // test_aeq_chain
